// ---- shared/sfpc_pkg.sv ----
// Purpose: shared constants and types for the sector flash host controller
// Assumes: 20 MHz clock, byte-wide parallel flash with low-active strobes
// Notes: timing figures kept in their printed units, cycle counts derived
package sfpc_pkg;
    ////////////////////////////////////////////////////////////////////////
    // geometry
    localparam int ADDR_W = 18; // full byte address
    localparam int DATA_W = 8; // data lines
    localparam int SECT_LSB = 8; // sector_address_lines start here
    localparam int CMD_ADDR_W = 15; // command_address_lines width
    localparam int TOGGLE_BIT = 6; // toggle_status_bit position
    localparam int SEQ_LEN = 3; // writes in one command sequence
    localparam logic [1:0] SEQ_LAST = 2'h2; // index of last sequence write
    localparam logic [7:0] BYTE_LAST = 8'hFF; // last byte of a sector
    ////////////////////////////////////////////////////////////////////////
    // timing in printed units
    localparam int CLK_NS = 50; // clock period
    localparam int T_WP_NS = 200; // write pulse low, least
    localparam int T_WPH_NS = 200; // write pulse high, least
    localparam int T_ACC_NS = 120; // address or strobe to data, most
    localparam int T_OEHP_NS = 150; // output enable high pulse, least
    localparam int T_BLC_US = 150; // byte load window, most
    localparam int T_WC_MS = 20; // sector program cycle, most
    localparam int SYNC_CYC = 2; // input synchroniser depth
    // least time rounded up to whole cycles, never below one
    function automatic int ceil_cyc(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction : ceil_cyc
    localparam int WP_CYC = ceil_cyc(T_WP_NS);
    localparam int WPH_CYC = (ceil_cyc(T_WPH_NS) > ceil_cyc(T_OEHP_NS)) ? ceil_cyc(T_WPH_NS) : ceil_cyc(T_OEHP_NS);
    localparam int RD_CYC = ceil_cyc(T_ACC_NS) + SYNC_CYC;
    localparam int BLC_CYC = ceil_cyc(T_BLC_US * 1000);
    localparam int WC_CYC = ceil_cyc(T_WC_MS * 1000000);
    localparam int CNT_W = 4; // engine phase counter width
    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [2:0] {
        OP_READ = 3'h0, // one array or id read
        OP_PROGRAM = 3'h1, // protected sector program
        OP_ID_ENTER = 3'h2, // enter product identification
        OP_ID_EXIT = 3'h3, // leave product identification
        OP_LOCK_LOW = 3'h4, // lock lower boot block
        OP_LOCK_HIGH = 3'h5 // lock higher boot block
    } sfpc_op_t;
    typedef struct packed {
        logic write; // 1 write cycle, 0 read cycle
        logic [ADDR_W-1:0] addr; // byte address
        logic [DATA_W-1:0] data; // write data
    } sfpc_req_t;
    typedef struct packed {
        logic ce_n; // chip enable, low active
        logic oe_n; // output enable, low active
        logic we_n; // write enable, low active
        logic [ADDR_W-1:0] addr; // address lines
        logic [DATA_W-1:0] dq; // data out
        logic dq_oe; // high while host drives data
    } sfpc_pins_t;
endpackage : sfpc_pkg

// ---- hw/sfpc_bus_cycle.sv ----
// Purpose: one read or write strobe cycle on the flash pins
// Assumes: start only while idle; data input is asynchronous
// Notes: chip and output enable both return high after every cycle
`timescale 1ns/1ns
module sfpc_bus_cycle
    import sfpc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire sfpc_req_t i_req,
    input wire logic [DATA_W-1:0] i_dq,
    output sfpc_pins_t o_pins,
    output logic o_done,
    output logic [DATA_W-1:0] o_rdata
);
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        E_IDLE = 2'h0, // strobes high
        E_SET = 2'h1, // address and chip enable settle
        E_STB = 2'h3, // write or output enable low
        E_REC = 2'h2 // strobes high, address held
    } sfpc_eng_t;
    sfpc_eng_t st; // engine phase
    logic wr; // current cycle is a write
    logic [CNT_W-1:0] cnt; // phase length counter
    logic [DATA_W-1:0] dq_s1; // first sync stage
    logic [DATA_W-1:0] dq_s2; // second sync stage
    wire cnt_zero = (cnt == '0); // phase ends
    ////////////////////////////////////////////////////////////////////////
    // two-stage synchroniser on the data pins
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            dq_s1 <= 8'h00;
            dq_s2 <= 8'h00;
        end else begin
            dq_s1 <= i_dq;
            dq_s2 <= dq_s1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // strobe sequencer
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= E_IDLE;
            wr <= 1'b0;
            cnt <= '0;
            o_pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq: '0, dq_oe: 1'b0};
            o_done <= 1'b0;
            o_rdata <= 8'h00;
        end else begin
            o_done <= 1'b0;
            case (st)
                E_IDLE: begin
                    // latch request, select chip
                    if (i_start) begin
                        wr <= i_req.write;
                        o_pins.addr <= i_req.addr;
                        o_pins.dq <= i_req.data;
                        o_pins.dq_oe <= i_req.write;
                        o_pins.ce_n <= 1'b0;
                        st <= E_SET;
                    end
                end
                E_SET: begin
                    // output enable stays high on writes
                    o_pins.we_n <= ~wr;
                    o_pins.oe_n <= wr;
                    cnt <= wr ? CNT_W'(WP_CYC - 1) : CNT_W'(RD_CYC - 1);
                    st <= E_STB;
                end
                E_STB: begin
                    // end of pulse; both enables rise so each read is fresh
                    if (cnt_zero) begin
                        o_pins.we_n <= 1'b1;
                        o_pins.oe_n <= 1'b1;
                        o_pins.ce_n <= 1'b1;
                        if (!wr) begin
                            o_rdata <= dq_s2;
                        end
                        cnt <= CNT_W'(WPH_CYC - 1);
                        st <= E_REC;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                E_REC: begin
                    // data hold then release
                    o_pins.dq_oe <= 1'b0;
                    if (cnt_zero) begin
                        o_done <= 1'b1;
                        st <= E_IDLE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                default: st <= E_IDLE;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    strobe_excl_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (!o_pins.we_n && !o_pins.ce_n) |-> o_pins.oe_n)
        else $error("output enable low during a write");
    pulse_width_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $fell(o_pins.we_n) |-> (!o_pins.we_n && o_pins.dq_oe)[*4] ##1 o_pins.we_n)
        else $error("write pulse width wrong");
endmodule : sfpc_bus_cycle

// ---- hw/sfpc_host.sv ----
// Purpose: host controller that programs, reads and identifies a sector flash
// Assumes: flash pins wired directly; command codes supplied as parameters
// Notes: completion found by watching the toggle status bit
`timescale 1ns/1ns
module sfpc_host
    import sfpc_pkg::*;
#(
    parameter int P_WC_CYC = WC_CYC, // program cycle limit
    parameter int P_BLC_CYC = BLC_CYC, // wait before polling starts
    parameter logic [CMD_ADDR_W-1:0] P_CMD_ADDR_A = 15'h1111, // first command address
    parameter logic [CMD_ADDR_W-1:0] P_CMD_ADDR_B = 15'h2222, // second command address
    parameter logic [DATA_W-1:0] P_CMD_DATA_A = 8'h11, // first command byte
    parameter logic [DATA_W-1:0] P_CMD_DATA_B = 8'h22, // second command byte
    parameter logic [DATA_W-1:0] P_CODE_PROG = 8'h33, // program code
    parameter logic [DATA_W-1:0] P_CODE_ID_ENTER = 8'h44, // id entry code
    parameter logic [DATA_W-1:0] P_CODE_ID_EXIT = 8'h55, // id exit code
    parameter logic [DATA_W-1:0] P_CODE_LOCK_LOW = 8'h66, // lower lockout code
    parameter logic [DATA_W-1:0] P_CODE_LOCK_HIGH = 8'h77 // higher lockout code
)(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_cmd_valid,
    input wire sfpc_op_t i_cmd,
    input wire logic [ADDR_W-1:0] i_addr,
    output logic o_cmd_ready,
    input wire logic i_wvalid,
    input wire logic [DATA_W-1:0] i_wdata,
    output logic o_wready,
    output logic o_done,
    output logic o_timeout,
    output logic [DATA_W-1:0] o_rdata,
    output logic o_ce_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic [ADDR_W-1:0] o_addr,
    output logic [DATA_W-1:0] o_dq,
    output logic o_dq_oe,
    input wire logic [DATA_W-1:0] i_dq
);
    ////////////////////////////////////////////////////////////////////////
    localparam int LIMIT = P_BLC_CYC + P_WC_CYC; // poll gives up here
    localparam int WC_W = $clog2(LIMIT + 1); // wait counter width
    typedef enum logic [2:0] {
        S_IDLE = 3'h0, // waiting for a command
        S_SEQ = 3'h1, // command sequence writes
        S_LOAD = 3'h3, // sector byte loads
        S_WAIT = 3'h2, // load window closes
        S_POLL = 3'h6, // toggle polling
        S_READ = 3'h7, // single read
        S_DONE = 3'h5 // completion pulse
    } sfpc_state_t;
    sfpc_state_t state; // main state
    sfpc_op_t op; // latched operation
    logic [ADDR_W-1:0] addr_q; // latched target address
    logic [1:0] seq_idx; // sequence write index
    logic [7:0] byte_idx; // byte within sector
    logic pending; // engine cycle outstanding
    logic go; // engine start pulse
    sfpc_req_t req; // engine request
    logic tog_prev; // previous toggle bit
    logic tog_valid; // one status read seen
    logic [WC_W-1:0] wcnt; // wait and timeout counter
    sfpc_pins_t pins; // engine pin state
    logic eng_done; // engine finished a cycle
    logic [DATA_W-1:0] eng_rdata; // engine read data
    ////////////////////////////////////////////////////////////////////////
    // one write of a command sequence, upper address lines low
    function automatic sfpc_req_t seq_step(input logic [1:0] idx, input logic [DATA_W-1:0] code);
        sfpc_req_t r;
        r.write = 1'b1;
        r.addr = {3'h0, (idx == 2'h1) ? P_CMD_ADDR_B : P_CMD_ADDR_A};
        r.data = (idx == 2'h0) ? P_CMD_DATA_A : ((idx == 2'h1) ? P_CMD_DATA_B : code);
        return r;
    endfunction : seq_step
    ////////////////////////////////////////////////////////////////////////
    // decode of the operation into its code and following phase
    wire [DATA_W-1:0] op_code = (op == OP_PROGRAM) ? P_CODE_PROG :
                                (op == OP_ID_ENTER) ? P_CODE_ID_ENTER :
                                (op == OP_ID_EXIT) ? P_CODE_ID_EXIT :
                                (op == OP_LOCK_LOW) ? P_CODE_LOCK_LOW : P_CODE_LOCK_HIGH;
    wire sfpc_state_t after_seq = (op == OP_PROGRAM) ? S_LOAD :
                                  (op == OP_LOCK_LOW || op == OP_LOCK_HIGH) ? S_WAIT : S_DONE;
    wire sfpc_req_t seq_req = seq_step(seq_idx, op_code);
    wire sfpc_req_t load_req = '{write: 1'b1, addr: {addr_q[ADDR_W-1:SECT_LSB], byte_idx}, data: i_wdata};
    wire sfpc_req_t read_req = '{write: 1'b0, addr: addr_q, data: 8'h00};
    wire take_byte = (state == S_LOAD) && !pending && o_wready && i_wvalid;
    wire tog_now = eng_rdata[TOGGLE_BIT];
    wire tog_same = tog_valid && (tog_now == tog_prev);
    wire timed_out = (wcnt >= WC_W'(LIMIT));
    ////////////////////////////////////////////////////////////////////////
    // pin engine
    sfpc_bus_cycle u_cycle (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_start(go),
        .i_req(req),
        .i_dq(i_dq),
        .o_pins(pins),
        .o_done(eng_done),
        .o_rdata(eng_rdata)
    );
    // pins come straight from engine flip-flops
    assign o_ce_n = pins.ce_n;
    assign o_oe_n = pins.oe_n;
    assign o_we_n = pins.we_n;
    assign o_addr = pins.addr;
    assign o_dq = pins.dq;
    assign o_dq_oe = pins.dq_oe;
    ////////////////////////////////////////////////////////////////////////
    // wait counter runs through the load window and polling
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wcnt <= '0;
        end else if (state == S_WAIT || state == S_POLL) begin
            wcnt <= timed_out ? wcnt : wcnt + 1'b1;
        end else begin
            wcnt <= '0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // operation sequencer
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= S_IDLE;
            op <= OP_READ;
            addr_q <= '0;
            seq_idx <= 2'h0;
            byte_idx <= 8'h00;
            pending <= 1'b0;
            go <= 1'b0;
            req <= '0;
            tog_prev <= 1'b0;
            tog_valid <= 1'b0;
            o_cmd_ready <= 1'b1;
            o_wready <= 1'b0;
            o_done <= 1'b0;
            o_timeout <= 1'b0;
            o_rdata <= 8'h00;
        end else begin
            go <= 1'b0;
            o_done <= 1'b0;
            case (state)
                S_IDLE: begin
                    // accept a command
                    if (i_cmd_valid && o_cmd_ready) begin
                        op <= i_cmd;
                        addr_q <= i_addr;
                        seq_idx <= 2'h0;
                        o_cmd_ready <= 1'b0;
                        o_timeout <= 1'b0;
                        state <= (i_cmd == OP_READ) ? S_READ : S_SEQ;
                    end
                end
                S_SEQ: begin
                    // three command writes
                    if (!pending) begin
                        go <= 1'b1;
                        req <= seq_req;
                        pending <= 1'b1;
                    end else if (eng_done) begin
                        pending <= 1'b0;
                        if (seq_idx == SEQ_LAST) begin
                            state <= after_seq;
                            byte_idx <= 8'h00;
                            o_wready <= (after_seq == S_LOAD);
                        end else begin
                            seq_idx <= seq_idx + 1'b1;
                        end
                    end
                end
                S_LOAD: begin
                    // every byte of the sector, in order
                    if (take_byte) begin
                        go <= 1'b1;
                        req <= load_req;
                        pending <= 1'b1;
                        o_wready <= 1'b0;
                    end else if (pending && eng_done) begin
                        pending <= 1'b0;
                        byte_idx <= byte_idx + 1'b1;
                        if (byte_idx == BYTE_LAST) begin
                            state <= S_WAIT;
                        end else begin
                            o_wready <= 1'b1;
                        end
                    end
                end
                S_WAIT: begin
                    // let the load window lapse so the cycle has begun
                    tog_valid <= 1'b0;
                    if (wcnt == WC_W'(P_BLC_CYC - 1)) begin
                        state <= S_POLL;
                    end
                end
                S_POLL: begin
                    // repeated status reads, same address each time
                    if (!pending) begin
                        go <= 1'b1;
                        req <= read_req;
                        pending <= 1'b1;
                    end else if (eng_done) begin
                        pending <= 1'b0;
                        tog_prev <= tog_now;
                        tog_valid <= 1'b1;
                        if (tog_same) begin
                            o_rdata <= eng_rdata;
                            state <= S_DONE;
                        end else if (timed_out) begin
                            o_timeout <= 1'b1;
                            state <= S_DONE;
                        end
                    end
                end
                S_READ: begin
                    // single read; id codes appear here in id mode
                    if (!pending) begin
                        go <= 1'b1;
                        req <= read_req;
                        pending <= 1'b1;
                    end else if (eng_done) begin
                        pending <= 1'b0;
                        o_rdata <= eng_rdata;
                        state <= S_DONE;
                    end
                end
                S_DONE: begin
                    // completion pulse
                    o_done <= 1'b1;
                    o_cmd_ready <= 1'b1;
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sector_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
        ($fell(o_we_n) && state == S_LOAD) |-> (o_addr[ADDR_W-1:SECT_LSB] == addr_q[ADDR_W-1:SECT_LSB]))
        else $error("sector address moved during load");
    all_bytes_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state == S_WAIT && $past(state) == S_LOAD) |-> ($past(byte_idx) == 8'hFF && byte_idx == 8'h00))
        else $error("program started before all bytes loaded");
    toggle_pair_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state == S_DONE && $past(state) == S_POLL && !o_timeout) |->
        ($past(tog_valid) && o_rdata[TOGGLE_BIT] == $past(tog_prev)))
        else $error("poll ended without two equal toggle reads");
    poll_addr_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (go && state == S_POLL) |-> (!req.write && req.addr == addr_q) ##1 (o_ce_n == 1'b0) ##1 (o_addr == addr_q))
        else $error("status read address changed");
    cmd_addr_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (go && state == S_SEQ) |-> ##1 (o_dq_oe && o_addr[ADDR_W-1:CMD_ADDR_W] == 3'h0))
        else $error("command write outside command address lines");
    wait_bound_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_done && o_timeout) |-> ($past(wcnt) == WC_W'(LIMIT)))
        else $error("poll gave up before its limit");
endmodule : sfpc_host

// ---- bench/sfpc_flash_model.sv ----
// Purpose: behavioural sector flash seen by the host controller
// Assumes: low active strobes, model times kept in ns
// Notes: released data lines show the inverse of the last value
`timescale 1ns/1ns
module sfpc_flash_model
    import sfpc_pkg::*;
#(
    parameter logic [7:0] P_MAKER = 8'h5A, // arbitrary value
    parameter logic [7:0] P_PART = 8'hC3 // arbitrary value
)(
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_dq,
    input wire logic i_pwr_ok,
    output logic [DATA_W-1:0] o_dq
);
    logic [7:0] mem [0:262143]; // array, erased
    logic [7:0] buf_d [0:255]; // sector latches
    logic [9:0] sect = 10'h000; // sector being loaded
    logic [7:0] rd = 8'h00; // last driven value
    logic [ADDR_W-1:0] poll_a; // previous status address
    logic id = 1'b0, loading = 1'b0, busy = 1'b0, polled = 1'b0, lock_lo = 1'b0, lock_hi = 1'b0;
    int cnt = 0, nload = 0, viol = 0, busy_ns = 3000;
    time t_last, t_end;
    initial foreach (mem[k]) mem[k] = 8'hFF;
    assign o_dq = (!i_ce_n && !i_oe_n) ? rd : ~rd;
    ////////////////////////////////////////////////////////////////////////
    // either enable falling while the other is already low refreshes the read value
    always @(negedge i_oe_n or negedge i_ce_n) begin
        if (!i_oe_n && !i_ce_n) begin
            if (busy) begin
                if (polled && i_addr != poll_a) viol++;
                poll_a = i_addr;
                polled = 1'b1;
                rd = rd ^ 8'h40;
            end else if (id && i_addr[17:1] == '0) rd = i_addr[0] ? P_PART : P_MAKER;
            else rd = mem[i_addr];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // writes: sector loads and command sequences
    always @(negedge i_we_n) begin
        if (!i_ce_n) begin
            if (!i_oe_n) viol++;
            else if (loading) begin
                if (nload > 0 && i_addr[17:8] != sect) viol++;
                sect = i_addr[17:8];
                buf_d[i_addr[7:0]] = i_dq;
                nload++;
                t_last = $time;
            end else if (cnt == 2 && i_addr[14:0] == 15'h1111) begin
                cnt = 0;
                case (i_dq)
                    8'h33: begin loading = 1'b1; nload = 0; t_last = $time; end
                    8'h44: id = 1'b1;
                    8'h55: id = 1'b0;
                    8'h66: begin lock_lo = 1'b1; busy = 1'b1; polled = 1'b0; t_end = $time + busy_ns; end
                    8'h77: begin lock_hi = 1'b1; busy = 1'b1; polled = 1'b0; t_end = $time + busy_ns; end
                    default: cnt = 0;
                endcase
            end else if (cnt == 0 && i_addr[14:0] == 15'h1111 && i_dq == 8'h11) cnt = 1;
            else if (cnt == 1 && i_addr[14:0] == 15'h2222 && i_dq == 8'h22) cnt = 2;
            else cnt = 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // load window, program timer and power loss
    always #50 begin
        if (loading && $time - t_last > 800) begin
            if (nload != 256) viol++;
            for (int k = 0; k < 256; k++) mem[{sect, k[7:0]}] = buf_d[k];
            loading = 1'b0;
            busy = 1'b1;
            polled = 1'b0;
            t_end = $time + busy_ns;
        end
        if (busy && $time >= t_end) busy = 1'b0;
        if (!i_pwr_ok) begin id = 1'b0; cnt = 0; end
    end
endmodule : sfpc_flash_model

// ---- bench/sector_flash_program_control_tb_top.sv ----
// Purpose: self-checking bench for the sector flash host controller
// Assumes: default command codes, shortened program and load waits
// Notes: expectations queued by the driver, checked at each done pulse
`timescale 1ns/1ns
module sector_flash_program_control_tb_top;
    import sfpc_pkg::*;
    logic i_clk = 1'b0, i_rst = 1'b1, cmd_valid = 1'b0, wvalid = 1'b0, pwr_ok = 1'b1;
    sfpc_op_t cmd = OP_READ;
    logic [17:0] addr = '0;
    logic [7:0] wdata = 8'h00, rdata, dq_o, dq_i, d [0:255], lo;
    logic [9:0] sect, expq [$]; // {care, timeout, rdata}
    logic cmd_ready, wready, done, tmo, ce_n, oe_n, we_n, dq_oe;
    logic [17:0] f_addr;
    int n_errors = 0, checks = 0, seed = 33;
    always #25 i_clk = ~i_clk;
    sfpc_host #(.P_WC_CYC(200), .P_BLC_CYC(20)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(cmd_valid),
        .i_cmd(cmd), .i_addr(addr), .o_cmd_ready(cmd_ready), .i_wvalid(wvalid), .i_wdata(wdata),
        .o_wready(wready), .o_done(done), .o_timeout(tmo), .o_rdata(rdata), .o_ce_n(ce_n), .o_oe_n(oe_n),
        .o_we_n(we_n), .o_addr(f_addr), .o_dq(dq_o), .o_dq_oe(dq_oe), .i_dq(dq_i));
    sfpc_flash_model m (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(f_addr), .i_dq(dq_o),
        .i_pwr_ok(pwr_ok), .o_dq(dq_i));
    ////////////////////////////////////////////////////////////////////////
    // compare, verdict, waits
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin n_errors++; $display("[ERR] %s expected %h seen %h", nm, e, g); end
    endtask : cmp
    task automatic close_out();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out
    task automatic idle();
        int n;
        n = 0;
        do begin @(posedge i_clk); n++; end while (cmd_ready !== 1'b1 && n < 30000);
        if (n >= 30000) begin n_errors++; close_out(); end
    endtask : idle
    // one command, sector bytes streamed back to back for a program
    task automatic run(input sfpc_op_t op, input logic [17:0] a, input logic [9:0] e);
        int n;
        expq.push_back(e);
        @(posedge i_clk);
        cmd_valid <= 1'b1; cmd <= op; addr <= a;
        idle();
        cmd_valid <= 1'b0;
        for (int i = 0; i < 256 && op == OP_PROGRAM; i++) begin
            wvalid <= 1'b1; wdata <= d[i];
            n = 0;
            do begin @(posedge i_clk); n++; end while (wready !== 1'b1 && n < 100);
            if (n >= 100) begin n_errors++; close_out(); end
        end
        wvalid <= 1'b0;
    endtask : run
    ////////////////////////////////////////////////////////////////////////
    // result watcher
    always @(posedge i_clk) begin
        if (done === 1'b1) begin
            if (expq.size() == 0) begin n_errors++; $display("[ERR] done expected 0 seen 1"); end
            else begin
                cmp("timeout", {7'h00, expq[0][8]}, {7'h00, tmo});
                if (expq[0][9]) cmp("rdata", expq[0][7:0], rdata);
                void'(expq.pop_front());
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        for (int i = 0; i < 256; i++) d[i] = 8'($random(seed));
        sect = 10'h001 + 10'($random(seed) & 32'h1FF);
        lo = 8'($random(seed));
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        run(OP_PROGRAM, {sect, lo}, {2'b10, d[lo]});
        for (int i = 0; i < 4; i++) run(OP_READ, {sect, 8'(i * 85)}, {2'b10, d[i * 85]});
        $display("test program done");
        run(OP_ID_ENTER, 18'h0, 10'h0);
        run(OP_READ, 18'h0, {2'b10, 8'h5A});
        run(OP_READ, 18'h1, {2'b10, 8'hC3});
        run(OP_ID_EXIT, 18'h0, 10'h0);
        run(OP_READ, 18'h1, {2'b10, 8'hFF});
        $display("test identification done");
        run(OP_LOCK_LOW, 18'h0, {2'b10, 8'hFF});
        run(OP_LOCK_HIGH, 18'h0, {2'b10, 8'hFF});
        idle();
        cmp("lock low", 8'h01, {7'h00, m.lock_lo});
        cmp("lock high", 8'h01, {7'h00, m.lock_hi});
        m.busy_ns = 30000;
        run(OP_LOCK_LOW, 18'h0, 10'h100);
        idle();
        #30000 m.busy_ns = 3000;
        $display("test lockout done");
        run(OP_ID_ENTER, 18'h0, 10'h0);
        idle();
        i_rst <= 1'b1; pwr_ok <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0; pwr_ok <= 1'b1;
        run(OP_READ, 18'h0, {2'b10, 8'hFF});
        idle();
        @(posedge i_clk); // watcher takes the last note first
        cmp("queue left", 8'h00, 8'(expq.size()));
        cmp("model faults", 8'h00, 8'(m.viol));
        $display("test power loss done");
        close_out();
    end
endmodule : sector_flash_program_control_tb_top
